/* core/i2ca_top.sv */
// i2c slave address control: registers, address recognition, stretching
// assumes an Avalon-MM master on the bus clock and open-drain SCL/SDA pads
`timescale 1ns/100ps
`default_nettype none
module i2ca_top #(
  parameter int unsigned STRETCH_CYC = i2ca_pkg::SLAVE_LOW_CYC
) (
  input  wire logic        SYS_CLK_I,
  input  wire logic        ARST_N_I,
  input  wire logic [5:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  input  wire logic        SCL_I,
  output logic             SCL_O,
  output logic             SCL_OE_O,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE_O,
  output logic             PAD_HIGH_DRIVE_O,
  output logic             IRQ_O
);
  localparam int unsigned CW = $clog2(STRETCH_CYC + 1);

  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // register bus state
  i2ca_pkg::i2ca_ctrl_t ctrl;
  i2ca_pkg::i2ca_ctrl_t next_ctrl;
  logic [7:0]  range_lim;
  logic [7:0]  next_range_lim;
  logic [7:0]  primary;
  logic [7:0]  next_primary;
  logic [2:0]  status;
  logic [2:0]  next_status;
  logic [2:0]  mask;
  logic [2:0]  next_mask;
  logic        ack;
  logic        next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        irq;
  logic        next_irq;

  // link state
  i2ca_pkg::i2ca_state_t state;
  i2ca_pkg::i2ca_state_t next_state;
  logic [7:0]  shift;
  logic [7:0]  next_shift;
  logic [7:0]  first;
  logic [7:0]  next_first;
  logic [3:0]  bitcnt;
  logic [3:0]  next_bitcnt;
  logic [CW-1:0] hold;
  logic [CW-1:0] next_hold;
  logic [2:0]  ev;

  i2ca_pkg::i2ca_bus_t   bus;
  i2ca_pkg::i2ca_match_t m;

  i2ca_bus_sense u_sense (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (rst_n),
    .scl_i   (SCL_I),
    .sda_i   (SDA_I),
    .bus_o   (bus)
  );

  i2ca_addr_match u_match (
    .ctrl_i    (ctrl),
    .primary_i (primary),
    .range_i   (range_lim),
    .first_i   ((state == i2ca_pkg::ST_ADDR1) ? shift : first),
    .second_i  (shift),
    .match_o   (m)
  );

  // ---------------- register bus ----------------
  logic       req;
  logic       wr_en;
  logic [3:0] idx;

  // zero-extends a register into a bus word
  function automatic logic [31:0] word_of(input logic [7:0] v);
    word_of = {24'h000000, v};
  endfunction

  always_comb begin
    req         = AVS_READ_I | AVS_WRITE_I;
    idx         = AVS_ADDRESS_I[5:2];
    wr_en       = AVS_WRITE_I & ack & AVS_BYTEENABLE_I[0];
    next_ack    = req & ~ack;
    next_ctrl      = ctrl;
    next_range_lim = range_lim;
    next_primary   = primary;
    next_mask      = mask;
    next_status    = status;
    next_rdata     = rdata;
    // interrupt line lands one cycle after the status bit
    next_irq       = |(status & mask);
    if (wr_en) begin
      unique case (idx)
        i2ca_pkg::IDX_CTRL:    next_ctrl      = AVS_WRITEDATA_I[7:0];
        i2ca_pkg::IDX_RANGE:   next_range_lim = AVS_WRITEDATA_I[7:0];
        i2ca_pkg::IDX_PRIMARY: next_primary   = AVS_WRITEDATA_I[7:0];
        i2ca_pkg::IDX_MASK:    next_mask      = AVS_WRITEDATA_I[2:0];
        i2ca_pkg::IDX_STATUS:  next_status    = status & ~AVS_WRITEDATA_I[2:0];
        default:               next_status    = status;
      endcase
    end
    // set wins over clear
    next_status = next_status | ev;
    if (AVS_READ_I & ~ack) begin
      unique case (idx)
        i2ca_pkg::IDX_CTRL:    next_rdata = word_of(ctrl);
        i2ca_pkg::IDX_RANGE:   next_rdata = word_of(range_lim);
        i2ca_pkg::IDX_PRIMARY: next_rdata = word_of(primary);
        i2ca_pkg::IDX_STATUS:  next_rdata = word_of({5'h00, status});
        i2ca_pkg::IDX_MASK:    next_rdata = word_of({5'h00, mask});
        default:               next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl      <= i2ca_pkg::CTRL_RST;
      range_lim <= i2ca_pkg::RANGE_RST;
      primary   <= i2ca_pkg::PRIMARY_RST;
      status    <= i2ca_pkg::STATUS_RST;
      mask      <= i2ca_pkg::MASK_RST;
      ack       <= 1'b0;
      rdata     <= 32'h00000000;
      irq       <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      range_lim <= next_range_lim;
      primary   <= next_primary;
      status    <= next_status;
      mask      <= next_mask;
      ack       <= next_ack;
      rdata     <= next_rdata;
      irq       <= next_irq;
    end
  end

  assign AVS_WAITREQUEST_O = req & ~ack;
  assign AVS_READDATA_O    = rdata;
  assign IRQ_O             = irq;
  assign PAD_HIGH_DRIVE_O  = ctrl.high_drive;

  // ---------------- address recognition ----------------
  logic byte_done;

  always_comb begin
    byte_done   = bus.scl_fall & (bitcnt == 4'h8);
    next_state  = state;
    next_shift  = shift;
    next_first  = first;
    next_bitcnt = bitcnt;
    ev          = 3'h0;
    if (bus.scl_rise & (bitcnt != 4'h8)) begin
      next_shift  = {shift[6:0], bus.sda};
      next_bitcnt = bitcnt + 4'h1;
    end
    unique case (state)
      i2ca_pkg::ST_IDLE: begin
        next_bitcnt = 4'h0;
      end
      i2ca_pkg::ST_ADDR1: begin
        if (byte_done) begin
          next_first  = shift;
          next_bitcnt = 4'h0;
          if (m.hit7 | m.hdr_ok) begin
            next_state = i2ca_pkg::ST_ACK1;
          end else begin
            next_state = i2ca_pkg::ST_SKIP;
          end
          if (m.hit7) begin
            ev[i2ca_pkg::IRQ_MATCH] = 1'b1;
            ev[i2ca_pkg::IRQ_GC]    = m.gc_hit;
            ev[i2ca_pkg::IRQ_RANGE] = m.range_hit;
          end
        end
      end
      i2ca_pkg::ST_ACK1: begin
        next_bitcnt = 4'h0;
        if (bus.scl_fall) begin
          // 10-bit header matched: second byte still to come
          if (ctrl.ten_bit & m.hdr_ok & ~first[0]) begin
            next_state = i2ca_pkg::ST_ADDR2;
          end else begin
            next_state = i2ca_pkg::ST_HOLD;
          end
        end
      end
      i2ca_pkg::ST_ADDR2: begin
        if (byte_done) begin
          next_bitcnt = 4'h0;
          if (m.hit10) begin
            next_state = i2ca_pkg::ST_ACK2;
            ev[i2ca_pkg::IRQ_MATCH] = 1'b1;
          end else begin
            next_state = i2ca_pkg::ST_SKIP;
          end
        end
      end
      i2ca_pkg::ST_ACK2: begin
        next_bitcnt = 4'h0;
        if (bus.scl_fall) begin
          next_state = i2ca_pkg::ST_HOLD;
        end
      end
      i2ca_pkg::ST_HOLD,
      i2ca_pkg::ST_SKIP: begin
        next_bitcnt = 4'h0;
      end
    endcase
    // repeated start restarts recognition, stop ends it
    if (bus.start) begin
      next_state  = i2ca_pkg::ST_ADDR1;
      next_bitcnt = 4'h0;
    end else if (bus.stop) begin
      next_state  = i2ca_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state  <= i2ca_pkg::ST_IDLE;
      shift  <= 8'h00;
      first  <= 8'h00;
      bitcnt <= 4'h0;
    end else begin
      state  <= next_state;
      shift  <= next_shift;
      first  <= next_first;
      bitcnt <= next_bitcnt;
    end
  end

  // ---------------- scl stretching ----------------
  logic engaged;

  always_comb begin
    engaged   = (state != i2ca_pkg::ST_IDLE) & (state != i2ca_pkg::ST_SKIP);
    next_hold = hold;
    // own rate: hold scl low for our minimum low time
    if (bus.scl_fall & engaged & ctrl.rate_indep) begin
      next_hold = CW'(STRETCH_CYC);
    end else if (hold != '0) begin
      next_hold = hold - CW'(1);
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      hold <= '0;
    end else begin
      hold <= next_hold;
    end
  end

  // open drain: output value is always low, enable pulls the line
  assign SCL_O    = 1'b0;
  assign SCL_OE_O = (hold != '0);
  assign SDA_O    = 1'b0;
  assign SDA_OE_O = (state == i2ca_pkg::ST_ACK1) | (state == i2ca_pkg::ST_ACK2);
endmodule
`default_nettype wire

/* common/i2ca_pkg.sv */
// constants, layouts and types of the i2c slave address control block
// assumes a 250 MHz bus clock and word-aligned Avalon-MM register access
// Functional notes
// - general call address matches only while general_call_enable is set; code also matches address 0 as the 7-bit primary when primary is 0
// - address_width_select: 0 gives 7-bit, 1 gives 10-bit slave addressing
// - three upper address bits live here, compared only in 10-bit mode
// - range_match_enable: match above primary address, up to range limit inclusive; code applies it in 7-bit mode only
// - range_match_enable clear: no match arises from range comparison
// - independent_slave_rate_control picks own slave rate or follows the master
// - own slave rate forces SCL stretching; master must honour stretched SCL
// - pad_drive_strength_select drives a pad output: 0 normal, 1 high drive
// - any address match raises the pending interrupt flag
`default_nettype none
package i2ca_pkg;

  // clock and stretch timing
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned SLAVE_LOW_NS  = 1300;
  localparam int unsigned SLAVE_LOW_CYC =
    (SLAVE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_CTRL    = 4'h5;
  localparam logic [3:0] IDX_RANGE   = 4'h7;
  localparam logic [3:0] IDX_PRIMARY = 4'h8;
  localparam logic [3:0] IDX_STATUS  = 4'h9;
  localparam logic [3:0] IDX_MASK    = 4'ha;

  // reset values
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] RANGE_RST   = 8'h00;
  localparam logic [7:0] PRIMARY_RST = 8'h00;
  localparam logic [2:0] STATUS_RST  = 3'h0;
  localparam logic [2:0] MASK_RST    = 3'h0;

  // interrupt status / mask bit positions
  localparam int unsigned IRQ_MATCH = 0;
  localparam int unsigned IRQ_GC    = 1;
  localparam int unsigned IRQ_RANGE = 2;

  // address codes on the wire
  localparam logic [6:0] GC_ADDR    = 7'h00;
  localparam logic [4:0] TENBIT_HDR = 5'h1e;

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       gc_en;
    logic       ten_bit;
    logic       high_drive;
    logic       rate_indep;
    logic       range_en;
    logic [2:0] addr_hi;
  } i2ca_ctrl_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } i2ca_bus_t;

  typedef struct packed {
    logic hdr_ok;
    logic hit7;
    logic hit10;
    logic gc_hit;
    logic range_hit;
  } i2ca_match_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR1,
    ST_ACK1,
    ST_ADDR2,
    ST_ACK2,
    ST_HOLD,
    ST_SKIP
  } i2ca_state_t;

endpackage
`default_nettype wire

/* core/i2ca_bus_sense.sv */
// synchronises SCL/SDA and reports edges, start and stop
// assumes pins are asynchronous to the clock
`timescale 1ns/100ps
`default_nettype none
module i2ca_bus_sense (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output i2ca_pkg::i2ca_bus_t    bus_o
);
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_d;
  logic       sda_d;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end

  always_comb begin
    bus_o.scl      = scl_sync[1];
    bus_o.sda      = sda_sync[1];
    bus_o.scl_rise = scl_sync[1] & ~scl_d;
    bus_o.scl_fall = ~scl_sync[1] & scl_d;
    // sda moving while scl high
    bus_o.start    = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
    bus_o.stop     = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];
  end
endmodule
`default_nettype wire

/* core/i2ca_addr_match.sv */
// compares received address bytes against the programmed addresses
// assumes first byte holds address in bits 7:1 and r/w in bit 0
`timescale 1ns/100ps
`default_nettype none
module i2ca_addr_match (
  input  wire i2ca_pkg::i2ca_ctrl_t ctrl_i,
  input  wire logic [7:0]           primary_i,
  input  wire logic [7:0]           range_i,
  input  wire logic [7:0]           first_i,
  input  wire logic [7:0]           second_i,
  output i2ca_pkg::i2ca_match_t     match_o
);
  function automatic logic above(input logic [6:0] a, input logic [6:0] b);
    above = (a > b);
  endfunction

  logic [6:0] addr7;
  logic       exact7;

  always_comb begin
    addr7  = first_i[7:1];
    exact7 = ~ctrl_i.ten_bit & (addr7 == primary_i[7:1]);
    match_o.gc_hit = ctrl_i.gc_en & (addr7 == i2ca_pkg::GC_ADDR);
    match_o.range_hit = ~ctrl_i.ten_bit & ctrl_i.range_en
                      & above(addr7, primary_i[7:1])
                      & ~above(addr7, range_i[7:1]);
    match_o.hdr_ok = ctrl_i.ten_bit
                   & (first_i[7:3] == i2ca_pkg::TENBIT_HDR)
                   & ({1'b0, first_i[2:1]} == ctrl_i.addr_hi);
    match_o.hit7  = exact7 | match_o.gc_hit | match_o.range_hit;
    match_o.hit10 = match_o.hdr_ok & (second_i == primary_i);
  end
endmodule
`default_nettype wire

/* dv/i2ca_chk.sv */
// checker for i2ca_top: bus wait, pad, stretch, ack and irq timing
// assumes one Avalon request at a time, bound onto every i2ca_top
`timescale 1ns/100ps
`default_nettype none
module i2ca_chk #(
  parameter int unsigned STRETCH_CYC = 4
) (
  input wire logic        SYS_CLK_I,
  input wire logic        ARST_N_I,
  input wire logic [5:0]  AVS_ADDRESS_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [3:0]  AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic        AVS_WAITREQUEST_O,
  input wire logic        SCL_I,
  input wire logic        SCL_OE_O,
  input wire logic        SDA_OE_O,
  input wire logic        PAD_HIGH_DRIVE_O,
  input wire logic        IRQ_O
);
  logic       acc;
  logic       cw;
  logic       rate;
  logic       next_rate;
  logic [9:0] run;
  logic [9:0] next_run;
  logic [1:0] mwr;
  logic [1:0] next_mwr;
  always_comb begin
    acc = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0];
    cw = acc && AVS_ADDRESS_I[5:2] == i2ca_pkg::IDX_CTRL;
    next_rate = cw ? AVS_WRITEDATA_I[4] : rate;
    next_run = SCL_OE_O ? run + 10'h001 : 10'h000;
    next_mwr = {mwr[0], acc && AVS_ADDRESS_I[5:2] == i2ca_pkg::IDX_MASK};
  end
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rate <= 1'b0;
      run <= 10'h000;
      mwr <= 2'h0;
    end else begin
      rate <= next_rate;
      run <= next_run;
      mwr <= next_mwr;
    end
  end
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  AST_WAIT_FIRST: assert property ($rose(AVS_READ_I || AVS_WRITE_I) |-> AVS_WAITREQUEST_O)
    else $error("new request not held off");
  AST_ONE_WAIT: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O
    |=> !AVS_WAITREQUEST_O) else $error("more than one wait cycle");
  AST_RD_UPPER: assert property (AVS_READ_I && !AVS_WAITREQUEST_O
    |-> AVS_READDATA_O[31:8] == 24'h0) else $error("read data upper bits set");
  AST_RD_UNMAPPED: assert property (AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I[5:2] == 4'h3
    |-> AVS_READDATA_O == 32'h0) else $error("unmapped read not zero");
  AST_PAD_SET: assert property (cw |=> PAD_HIGH_DRIVE_O == $past(AVS_WRITEDATA_I[5]))
    else $error("pad drive not following write");
  AST_PAD_HOLD: assert property (!cw |=> $stable(PAD_HIGH_DRIVE_O))
    else $error("pad drive changed without write");
  AST_NO_STRETCH: assert property (!rate |-> !SCL_OE_O)
    else $error("stretch while following master rate");
  AST_STRETCH_LEN: assert property ($fell(SCL_OE_O) |-> run == 10'(STRETCH_CYC))
    else $error("stretch length wrong");
  AST_ACK_ON_LOW: assert property ($rose(SDA_OE_O) |-> !SCL_I)
    else $error("ack started while clock high");
  AST_ACK_HOLD: assert property ($rose(SDA_OE_O) |-> SDA_OE_O [*8])
    else $error("ack too short");
  AST_IRQ_CAUSE: assert property ($rose(IRQ_O) |-> SDA_OE_O || mwr != 2'h0)
    else $error("irq without match or mask write");
endmodule
bind i2ca_top i2ca_chk #(.STRETCH_CYC(STRETCH_CYC)) u_chk (.*);
`default_nettype wire

/* dv/i2ca_master_model.sv */
// behavioural i2c master that addresses the block
// assumes open-drain lines resolved outside; 1 on an output releases
`timescale 1ns/100ps
`default_nettype none
module i2ca_master_model #(
  parameter int HALF = 12
) (
  input  wire logic clk_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output var logic  scl_o,
  output var logic  sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // release clock and wait out a slave stretch of up to 200 cycles
  task automatic scl_up;
    int n;
    n = 0;
    scl_o <= 1'b1;
    tick(1);
    while (scl_i !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    tick(HALF);
  endtask
  task automatic start;
    sda_o <= 1'b0;
    tick(HALF);
    scl_o <= 1'b0;
    tick(HALF);
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      sda_o <= (i == 0) ? 1'b1 : b[i-1];
      tick(HALF);
      scl_up;
      ack = (sda_i === 1'b0);
      scl_o <= 1'b0;
    end
    tick(HALF);
  endtask
  task automatic stop;
    sda_o <= 1'b0;
    tick(HALF);
    scl_up;
    sda_o <= 1'b1;
    tick(HALF);
  endtask
endmodule
`default_nettype wire

/* dv/i2ca_top_tb.sv */
// self-checking bench for i2ca_top with a behavioural i2c master
// assumes pull-ups on both lines, resolved here
`timescale 1ns/100ps
`default_nettype none
module i2ca_top_tb;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [5:0]  addr = 6'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [3:0]  be = 4'h1;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        waitreq;
  logic        scl_do, scl_oe, sda_do, sda_oe, pad, irq, scl_m, sda_m, ack;
  wire logic   scl = scl_m & ~(scl_oe & ~scl_do);
  wire logic   sda = sda_m & ~(sda_oe & ~sda_do);
  int          errors = 0;
  int          samples_checked = 0;
  int          stretch_seen = 0;
  always #2 clk = ~clk;
  always @(posedge clk) if (scl_oe === 1'b1) stretch_seen++;
  i2ca_top #(.STRETCH_CYC(30)) dut (.SYS_CLK_I(clk), .ARST_N_I(arst_n),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(be),
    .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
    .SCL_I(scl), .SCL_O(scl_do), .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(sda_do),
    .SDA_OE_O(sda_oe), .PAD_HIGH_DRIVE_O(pad), .IRQ_O(irq));
  i2ca_master_model mst (.clk_i(clk), .scl_i(scl), .sda_i(sda), .scl_o(scl_m), .sda_o(sda_m));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= {idx, 2'b00};
    rd <= !w;
    wr <= w;
    wdata <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    check("wait cycles", n, 32'h2);
  endtask
  task automatic put(input logic [3:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task automatic get(input string what, input logic [3:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    check(what, q, {24'h0, exp});
  endtask
  task automatic frame(input logic [7:0] b0, input logic two, input logic [7:0] b1);
    mst.start();
    mst.put_byte(b0, ack);
    if (two && ack) mst.put_byte(b1, ack);
    mst.stop();
  endtask
  task automatic t_regs;
    logic [3:0] idx[5] = '{4'h5, 4'h7, 4'h8, 4'h9, 4'ha};
    foreach (idx[i]) get("reset value", idx[i], 8'h00);
    check("pad at reset", {31'h0, pad}, 32'h0);
    get("unmapped", 4'h3, 8'h00);
    be <= 4'h0;
    put(4'h5, 8'hff);
    be <= 4'h1;
    get("ctrl lane off", 4'h5, 8'h00);
    put(4'h5, 8'h20);
    get("ctrl", 4'h5, 8'h20);
    check("pad high", {31'h0, pad}, 32'h1);
    put(4'h5, 8'h00);
    @(posedge clk);
    check("pad normal", {31'h0, pad}, 32'h0);
    $display("test registers done");
  endtask
  task automatic t_seven;
    put(4'h8, 8'ha0);
    put(4'ha, 8'h01);
    frame(8'ha0, 1'b0, 8'h00);
    check("ack exact", {31'h0, ack}, 32'h1);
    get("status", 4'h9, 8'h01);
    check("irq set", {31'h0, irq}, 32'h1);
    put(4'h9, 8'h07);
    repeat (2) @(posedge clk);
    check("irq clear", {31'h0, irq}, 32'h0);
    $display("test seven bit done");
  endtask
  task automatic t_range;
    logic [6:0] a[5] = '{7'h50, 7'h51, 7'h55, 7'h56, 7'h4f};
    put(4'h7, 8'haa);
    frame(8'ha6, 1'b0, 8'h00);
    check("range off", {31'h0, ack}, 32'h0);
    put(4'h5, 8'h08);
    foreach (a[i]) begin
      frame({a[i], 1'b0}, 1'b0, 8'h00);
      check("range", {31'h0, ack}, {31'h0, a[i] >= 7'h50 && a[i] <= 7'h55});
    end
    get("range status", 4'h9, 8'h05);
    put(4'h9, 8'h07);
    $display("test range done");
  endtask
  task automatic t_gc;
    put(4'h5, 8'h00);
    frame(8'h00, 1'b0, 8'h00);
    check("gc off", {31'h0, ack}, 32'h0);
    put(4'h5, 8'h80);
    frame(8'h00, 1'b0, 8'h00);
    check("gc on", {31'h0, ack}, 32'h1);
    get("gc status", 4'h9, 8'h03);
    put(4'h9, 8'h07);
    $display("test general call done");
  endtask
  task automatic t_ten;
    put(4'h5, 8'h42);
    put(4'h8, 8'h3c);
    frame(8'hf4, 1'b1, 8'h3c);
    check("ten match", {31'h0, ack}, 32'h1);
    frame(8'hf2, 1'b1, 8'h3c);
    check("ten upper", {31'h0, ack}, 32'h0);
    frame(8'hf4, 1'b1, 8'h3d);
    check("ten lower", {31'h0, ack}, 32'h0);
    frame(8'h3c, 1'b0, 8'h00);
    check("seven in ten", {31'h0, ack}, 32'h0);
    put(4'h9, 8'h07);
    $display("test ten bit done");
  endtask
  task automatic t_rate;
    put(4'h8, 8'ha0);
    put(4'h5, 8'h10);
    stretch_seen = 0;
    frame(8'ha0, 1'b0, 8'h00);
    check("ack stretched", {31'h0, ack}, 32'h1);
    check("stretch on", {31'h0, stretch_seen != 0}, 32'h1);
    put(4'h5, 8'h00);
    stretch_seen = 0;
    frame(8'ha0, 1'b0, 8'h00);
    check("stretch off", stretch_seen, 32'h0);
    $display("test slave rate done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_seven;
    t_range;
    t_gc;
    t_ten;
    t_rate;
    conclude;
  end
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    conclude;
  end
endmodule
`default_nettype wire
